// *** rtl/synth_mux_pkg.sv ***
// Constants and state types for the synthesizer serial command multiplexer
package synth_mux_pkg;

  // Command codes
  localparam logic [7:0] CMD_FUNC_WR   = 8'h01;
  localparam logic [7:0] CMD_FUNC_RD   = 8'h81;
  localparam logic [7:0] CMD_DIV_WR    = 8'h02;
  localparam logic [7:0] CMD_DIV_RD    = 8'h82;
  localparam logic [7:0] CMD_ATT_WR    = 8'h03;
  localparam logic [7:0] CMD_ATT_RD    = 8'h83;
  localparam logic [7:0] CMD_WP_WR     = 8'h04;
  localparam logic [7:0] CMD_WP_RD     = 8'h84;
  localparam logic [7:0] CMD_AUX_WR    = 8'h05;
  localparam logic [7:0] CMD_AUX_RD    = 8'h85;
  localparam logic [7:0] CMD_CORE_CH   = 8'h10;
  localparam logic [7:0] CMD_CORE_UPD  = 8'h11;
  localparam logic [7:0] CMD_DIV_APPLY = 8'h12;
  localparam logic [7:0] CMD_ATT_APPLY = 8'h13;
  localparam logic [7:0] CMD_ALL_APPLY = 8'h1f;
  localparam logic [7:0] CMD_TEMP_CH   = 8'h30;
  localparam logic [7:0] CMD_ADC_CH    = 8'h40;
  localparam logic [7:0] CMD_POT_CH    = 8'h50;
  localparam logic [7:0] CMD_MEM_CH    = 8'h70;

  // Power/function field positions
  localparam int FN_SUPPLY   = 0;
  localparam int FN_RF_EN    = 3;
  localparam int FN_CORE_PWR = 4;
  localparam int FN_LOCK     = 7;
  localparam logic [7:0] FUNC_WR_MASK = 8'h7f;

  // Reset values
  localparam logic [7:0] RST_FUNC = 8'h00;
  localparam logic [7:0] RST_DIV  = 8'h00;
  localparam logic [7:0] RST_ATT  = 8'h00;
  localparam logic [7:0] RST_WP   = 8'h00;
  localparam logic [7:0] RST_AUX  = 8'h00;

  // Divider and attenuator fields
  localparam int DIV_W = 3;
  localparam int ATT_W = 6;
  localparam int WP_BIT = 0;
  localparam logic [2:0] DIV_CODE_MAX  = 3'h5;
  localparam logic [6:0] DIV_RATIO_ONE = 7'h01;
  localparam logic [6:0] DIV_RATIO_TOP = 7'h40;
  localparam logic [5:0] ATT_FULL      = 6'h3f;

  // Aux select field
  localparam logic [1:0] AUX_LOW  = 2'h0;
  localparam logic [1:0] AUX_LOCK = 2'h1;
  localparam logic [1:0] AUX_MARK = 2'h2;
  localparam logic [1:0] AUX_HIGH = 2'h3;
  localparam int AUX_F_FUNC = 7;
  localparam int AUX_F_DIV  = 6;
  localparam int AUX_F_ATT  = 5;
  localparam int AUX_F_UPD  = 4;

  // Downstream channel indices
  localparam int NUM_CH = 5;
  localparam logic [2:0] CH_CORE = 3'h0;
  localparam logic [2:0] CH_TEMP = 3'h1;
  localparam logic [2:0] CH_ADC  = 3'h2;
  localparam logic [2:0] CH_POT  = 3'h3;
  localparam logic [2:0] CH_MEM  = 3'h4;

  // Serial bit counter marks
  localparam logic [4:0] CNT_CMD_LAST  = 5'h07;
  localparam logic [4:0] CNT_RD_FIRST  = 5'h08;
  localparam logic [4:0] CNT_DATA_LAST = 5'h0f;
  localparam logic [4:0] CNT_SAT       = 5'h10;

  typedef enum logic [1:0] {OP_NONE, OP_WRITE, OP_READ, OP_CHAN} op_e;

  typedef struct packed {
    logic [4:0] cnt;
    logic [6:0] sh;
    logic [7:0] cmd;
    op_e        op;
    logic [2:0] chan;
    logic [7:0] rd_val;
  } frame_s;

  typedef struct packed {
    logic [7:0] func;
    logic [7:0] div_buf;
    logic [7:0] att_buf;
    logic [7:0] wp;
    logic [7:0] aux_sel;
    logic [7:0] div_live;
    logic [7:0] att_live;
    logic       lock_s1;
    logic       lock_s2;
    logic       live_tgl;
    logic       upd_tgl;
    logic       mark_tgl;
  } keep_s;

endpackage : synth_mux_pkg

// *** rtl/synth_spi_command_mux.sv ***
// Serial command decoder, static control registers and downstream channel router
// Behaviour
// - Command 01 writes function byte, lines follow
// - Command 81 returns function byte
// - D0 supply on, D3 RF output on
// - D4 powers synthesis core; host reinitialises
// - D7 reads PLL lock, writes ignored
// - Command 02 stores divider buffer only
// - Command 82 returns divider buffer
// - Divider code gives two-power ratio, 11x 64
// - Command 03 stores attenuation buffer only
// - Command 83 returns attenuation buffer
// - Code zero 31.5 dB, 0.5 dB steps
// - Command 04 writes protect byte, line follows
// - Protect D0 low blocks pot writes
// - Command 84 returns protect byte
// - Commands 05/85 write/read aux select
// - Command 10 routes rest to core channel
// - Command 11 pulses core update line
// - Commands 12/13 apply divider/attenuation buffers
// - Command 1F applies both and pulses update
// - Commands 30/40/50 route sensor, converter, pot
// - Command 70 routes rest to memory channel
// - Command first, MSB first, rising edges
// - Read data changes on falling edges
// - Aux select: low, lock, marker, high
// - Marker rises with func/div/att/update events flagged in aux D7..D4, falls at select release
`timescale 1ns/100ps
`default_nettype none

module synth_spi_command_mux
  import synth_mux_pkg::*;
#(
  parameter int UPD_PULSE_CYCLES = 4
)(
  input  wire logic                            clk_sys,
  input  wire logic                            arst_n,
  input  wire logic                            host_serial_clock,
  input  wire logic                            host_select_n,
  input  wire logic                            host_serial_in,
  output logic                                 host_serial_out,
  input  wire logic                            pll_lock,
  output logic                                 supply_on,
  output logic                                 rf_out_en,
  output logic                                 synth_core_power,
  output logic                                 div_factor_bit2,
  output logic                                 div_factor_bit1,
  output logic                                 div_factor_bit0,
  output logic [6:0]                           div_ratio,
  output logic [synth_mux_pkg::ATT_W-1:0]      atten_code,
  output logic [synth_mux_pkg::ATT_W-1:0]      atten_half_db,
  output logic                                 pot_write_enable,
  output logic                                 synth_core_update,
  output logic                                 update_marker,
  output logic                                 aux_output_pin,
  output logic [synth_mux_pkg::NUM_CH-1:0]     chan_select_n,
  output logic [synth_mux_pkg::NUM_CH-1:0]     chan_sclk,
  output logic [synth_mux_pkg::NUM_CH-1:0]     chan_mosi,
  input  wire logic [synth_mux_pkg::NUM_CH-1:0] chan_miso
);

  import synth_mux_pkg::*;

  localparam int UPD_W = $clog2(UPD_PULSE_CYCLES + 1);

  typedef struct packed {
    logic             cs_s1;
    logic             cs_s2;
    logic             cs_prev;
    logic             lock_s1;
    logic             lock_s2;
    logic [2:0]       live_s;
    logic [2:0]       upd_s;
    logic [2:0]       mark_s;
    logic [7:0]       func;
    logic [DIV_W-1:0] div;
    logic [6:0]       ratio;
    logic [ATT_W-1:0] att;
    logic [ATT_W-1:0] att_half;
    logic             wp;
    logic [7:0]       aux_sel;
    logic             marker;
    logic [UPD_W-1:0] upd_cnt;
    logic             aux;
  } sys_s;

  frame_s frame_reg;
  frame_s frame_next;
  keep_s  keep_reg;
  keep_s  keep_next;
  sys_s   sys_reg;
  sys_s   sys_next;
  logic   miso_reg;
  logic   miso_next;
  logic   frame_rst_n;
  logic   chan_active;

  // Frame state is cleared by the select line itself; the serial clock may stop
  assign frame_rst_n = arst_n & ~host_select_n;

  function automatic logic [6:0] ratio_of(input logic [DIV_W-1:0] code);
    if (code > DIV_CODE_MAX)
      return DIV_RATIO_TOP;
    return 7'(DIV_RATIO_ONE << code);
  endfunction : ratio_of

  // Serial clock domain: command decode and register storage
  always_comb
  begin
    logic [7:0] byte_now;
    logic       mark;
    byte_now   = {frame_reg.sh, host_serial_in};
    mark       = 1'b0;
    frame_next = frame_reg;
    keep_next  = keep_reg;
    keep_next.lock_s1 = pll_lock;
    keep_next.lock_s2 = keep_reg.lock_s1;
    frame_next.sh = byte_now[6:0];
    if (frame_reg.cnt != CNT_SAT)
      frame_next.cnt = frame_reg.cnt + 5'h01;
    if (frame_reg.cnt == CNT_CMD_LAST)
    begin
      frame_next.cmd = byte_now;
      frame_next.op  = OP_NONE;
      unique case (byte_now)
        CMD_FUNC_WR, CMD_DIV_WR, CMD_ATT_WR, CMD_WP_WR, CMD_AUX_WR:
          frame_next.op = OP_WRITE;
        CMD_FUNC_RD:
        begin
          frame_next.op     = OP_READ;
          frame_next.rd_val = {keep_reg.lock_s2, keep_reg.func[FN_LOCK-1:0]};
        end
        CMD_DIV_RD:
        begin
          frame_next.op     = OP_READ;
          frame_next.rd_val = keep_reg.div_buf;
        end
        CMD_ATT_RD:
        begin
          frame_next.op     = OP_READ;
          frame_next.rd_val = keep_reg.att_buf;
        end
        CMD_WP_RD:
        begin
          frame_next.op     = OP_READ;
          frame_next.rd_val = keep_reg.wp;
        end
        CMD_AUX_RD:
        begin
          frame_next.op     = OP_READ;
          frame_next.rd_val = keep_reg.aux_sel;
        end
        CMD_CORE_CH:
        begin
          frame_next.op   = OP_CHAN;
          frame_next.chan = CH_CORE;
        end
        CMD_TEMP_CH:
        begin
          frame_next.op   = OP_CHAN;
          frame_next.chan = CH_TEMP;
        end
        CMD_ADC_CH:
        begin
          frame_next.op   = OP_CHAN;
          frame_next.chan = CH_ADC;
        end
        CMD_POT_CH:
        begin
          frame_next.op   = OP_CHAN;
          frame_next.chan = CH_POT;
        end
        CMD_MEM_CH:
        begin
          frame_next.op   = OP_CHAN;
          frame_next.chan = CH_MEM;
        end
        CMD_CORE_UPD:
        begin
          keep_next.upd_tgl = ~keep_reg.upd_tgl;
          mark = keep_reg.aux_sel[AUX_F_UPD];
        end
        CMD_DIV_APPLY:
        begin
          keep_next.div_live = keep_reg.div_buf;
          keep_next.live_tgl = ~keep_reg.live_tgl;
          mark = keep_reg.aux_sel[AUX_F_DIV];
        end
        CMD_ATT_APPLY:
        begin
          keep_next.att_live = keep_reg.att_buf;
          keep_next.live_tgl = ~keep_reg.live_tgl;
          mark = keep_reg.aux_sel[AUX_F_ATT];
        end
        CMD_ALL_APPLY:
        begin
          keep_next.div_live = keep_reg.div_buf;
          keep_next.att_live = keep_reg.att_buf;
          keep_next.live_tgl = ~keep_reg.live_tgl;
          keep_next.upd_tgl  = ~keep_reg.upd_tgl;
          mark = keep_reg.aux_sel[AUX_F_DIV] | keep_reg.aux_sel[AUX_F_ATT] | keep_reg.aux_sel[AUX_F_UPD];
        end
        default:
          frame_next.op = OP_NONE;
      endcase
    end
    // Only the first data byte is taken; later bytes of a frame are dropped
    if (frame_reg.cnt == CNT_DATA_LAST && frame_reg.op == OP_WRITE)
    begin
      unique case (frame_reg.cmd)
        CMD_FUNC_WR:
        begin
          keep_next.func     = byte_now & FUNC_WR_MASK;
          keep_next.live_tgl = ~keep_reg.live_tgl;
          mark = keep_reg.aux_sel[AUX_F_FUNC];
        end
        CMD_DIV_WR:
          keep_next.div_buf = byte_now;
        CMD_ATT_WR:
          keep_next.att_buf = byte_now;
        CMD_WP_WR:
        begin
          keep_next.wp       = byte_now;
          keep_next.live_tgl = ~keep_reg.live_tgl;
        end
        CMD_AUX_WR:
        begin
          keep_next.aux_sel  = byte_now;
          keep_next.live_tgl = ~keep_reg.live_tgl;
        end
        default:
          mark = 1'b0;
      endcase
    end
    keep_next.mark_tgl = keep_reg.mark_tgl ^ mark;
  end

  always_ff @(posedge host_serial_clock or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
      frame_reg <= '{cnt: 5'h00, sh: 7'h00, cmd: 8'h00, op: OP_NONE, chan: 3'h0, rd_val: 8'h00};
    else
      frame_reg <= frame_next;
  end

  always_ff @(posedge host_serial_clock or negedge arst_n)
  begin
    if (!arst_n)
      keep_reg <= '{func: RST_FUNC, div_buf: RST_DIV, att_buf: RST_ATT, wp: RST_WP, aux_sel: RST_AUX,
                    div_live: RST_DIV, att_live: RST_ATT, default: 1'b0};
    else
      keep_reg <= keep_next;
  end

  // Read data shifts out on the falling edge, half a period ahead of the sample
  always_comb
  begin
    logic [2:0] bit_idx;
    bit_idx   = 3'(CNT_DATA_LAST - frame_reg.cnt);
    miso_next = 1'b0;
    if (frame_reg.op == OP_READ && frame_reg.cnt >= CNT_RD_FIRST && frame_reg.cnt <= CNT_DATA_LAST)
      miso_next = frame_reg.rd_val[bit_idx];
  end

  always_ff @(negedge host_serial_clock or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
      miso_reg <= 1'b0;
    else
      miso_reg <= miso_next;
  end

  // Channel routing; clock is gated, so the routed device sees a rising edge at the last command edge, then data-phase edges
  assign chan_active = (frame_reg.op == OP_CHAN);

  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      chan_select_n[i] = ~(chan_active && frame_reg.chan == 3'(i));
      chan_sclk[i]     = ~chan_select_n[i] & host_serial_clock;
      chan_mosi[i]     = ~chan_select_n[i] & host_serial_in;
    end
    host_serial_out = miso_reg;
    if (chan_active)
      host_serial_out = chan_miso[frame_reg.chan];
  end

  // System clock domain: static lines, update pulse, marker and aux pin
  always_comb
  begin
    sys_next = sys_reg;
    sys_next.cs_s1   = host_select_n;
    sys_next.cs_s2   = sys_reg.cs_s1;
    sys_next.cs_prev = sys_reg.cs_s2;
    sys_next.lock_s1 = pll_lock;
    sys_next.lock_s2 = sys_reg.lock_s1;
    sys_next.live_s  = {sys_reg.live_s[1:0], keep_reg.live_tgl};
    sys_next.upd_s   = {sys_reg.upd_s[1:0], keep_reg.upd_tgl};
    sys_next.mark_s  = {sys_reg.mark_s[1:0], keep_reg.mark_tgl};
    // Words are stable here: the next change needs at least eight more serial edges
    if (sys_reg.live_s[2] ^ sys_reg.live_s[1])
    begin
      sys_next.func     = keep_reg.func;
      sys_next.div      = keep_reg.div_live[DIV_W-1:0];
      sys_next.ratio    = ratio_of(keep_reg.div_live[DIV_W-1:0]);
      sys_next.att      = keep_reg.att_live[ATT_W-1:0];
      sys_next.att_half = ATT_FULL - keep_reg.att_live[ATT_W-1:0];
      sys_next.wp       = keep_reg.wp[WP_BIT];
      sys_next.aux_sel  = keep_reg.aux_sel;
    end
    if (sys_reg.upd_s[2] ^ sys_reg.upd_s[1])
      sys_next.upd_cnt = UPD_W'(UPD_PULSE_CYCLES);
    else if (sys_reg.upd_cnt != '0)
      sys_next.upd_cnt = sys_reg.upd_cnt - 1'b1;
    // Set beats the end-of-frame clear
    if (sys_reg.mark_s[2] ^ sys_reg.mark_s[1])
      sys_next.marker = 1'b1;
    else if (sys_reg.cs_s2 && !sys_reg.cs_prev)
      sys_next.marker = 1'b0;
    unique case (sys_next.aux_sel[1:0])
      AUX_LOW:  sys_next.aux = 1'b0;
      AUX_LOCK: sys_next.aux = sys_reg.lock_s2;
      AUX_MARK: sys_next.aux = sys_next.marker;
      AUX_HIGH: sys_next.aux = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      sys_reg <= '{cs_s1: 1'b1, cs_s2: 1'b1, cs_prev: 1'b1, func: RST_FUNC, ratio: DIV_RATIO_ONE,
                   att_half: ATT_FULL, aux_sel: RST_AUX, default: '0};
    else
      sys_reg <= sys_next;
  end

  assign supply_on         = sys_reg.func[FN_SUPPLY];
  assign rf_out_en         = sys_reg.func[FN_RF_EN];
  assign synth_core_power  = sys_reg.func[FN_CORE_PWR];
  assign div_factor_bit2   = sys_reg.div[2];
  assign div_factor_bit1   = sys_reg.div[1];
  assign div_factor_bit0   = sys_reg.div[0];
  assign div_ratio         = sys_reg.ratio;
  assign atten_code        = sys_reg.att;
  assign atten_half_db     = sys_reg.att_half;
  assign pot_write_enable  = sys_reg.wp;
  assign synth_core_update = (sys_reg.upd_cnt != '0);
  assign update_marker     = sys_reg.marker;
  assign aux_output_pin    = sys_reg.aux;

endmodule : synth_spi_command_mux

`default_nettype wire

// *** rtl/unused_placeholder.sv ***
// Intentionally empty
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// *** dv/synth_mux_assertions.sv ***
// Port-level checks for the serial command multiplexer
`timescale 1ns/100ps
`default_nettype none
module synth_mux_assertions
  import synth_mux_pkg::*;
#(
  parameter int UPD_PULSE_CYCLES = 4
)(
  input  wire logic                               clk_sys,
  input  wire logic                               arst_n,
  input  wire logic                               host_serial_clock,
  input  wire logic                               host_select_n,
  input  wire logic                               host_serial_in,
  input  wire logic                               host_serial_out,
  input  wire logic                               supply_on,
  input  wire logic                               div_factor_bit2,
  input  wire logic                               div_factor_bit1,
  input  wire logic                               div_factor_bit0,
  input  wire logic [6:0]                         div_ratio,
  input  wire logic [synth_mux_pkg::ATT_W-1:0]    atten_code,
  input  wire logic [synth_mux_pkg::ATT_W-1:0]    atten_half_db,
  input  wire logic                               synth_core_update,
  input  wire logic                               update_marker,
  input  wire logic [synth_mux_pkg::NUM_CH-1:0]   chan_select_n,
  input  wire logic [synth_mux_pkg::NUM_CH-1:0]   chan_sclk,
  input  wire logic [synth_mux_pkg::NUM_CH-1:0]   chan_mosi
);
  logic [7:0] upd_cnt_reg;
  logic [2:0] div_code;
  assign div_code = {div_factor_bit2, div_factor_bit1, div_factor_bit0};
  // Counts high cycles of the update pulse
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      upd_cnt_reg <= 8'h00;
    else if (synth_core_update)
      upd_cnt_reg <= upd_cnt_reg + 8'h01;
    else
      upd_cnt_reg <= 8'h00;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence code_held;
    $stable(div_code);
  endsequence
  sequence upd_end;
    $fell(synth_core_update);
  endsequence
  chk_div_ratio_map: assert property (code_held |-> div_ratio ==
    ((div_code > DIV_CODE_MAX) ? DIV_RATIO_TOP : (DIV_RATIO_ONE << div_code))) else $error("divider ratio wrong");
  chk_atten_half_db: assert property ($stable(atten_code) |-> atten_half_db == ATT_FULL - atten_code)
    else $error("attenuation view wrong");
  chk_single_route: assert property ($onehot0(~chan_select_n))
    else $error("more than one channel selected");
  chk_idle_frame: assert property (host_select_n |-> chan_select_n == '1 && host_serial_out == 1'b0)
    else $error("idle frame not quiet");
  chk_clock_gate: assert property (chan_sclk == ({NUM_CH{host_serial_clock}} & ~chan_select_n))
    else $error("channel clock not gated");
  chk_data_gate: assert property (chan_mosi == ({NUM_CH{host_serial_in}} & ~chan_select_n))
    else $error("channel data not gated");
  chk_upd_width: assert property (upd_end |-> upd_cnt_reg == UPD_PULSE_CYCLES)
    else $error("update pulse width wrong");
  chk_upd_bound: assert property (upd_cnt_reg <= UPD_PULSE_CYCLES)
    else $error("update pulse too long");
  chk_marker_clear: assert property ($rose(host_select_n) |-> ##[1:6] !update_marker)
    else $error("marker not cleared");
  chk_reset_state: assert property (@(posedge clk_sys) disable iff (1'b0) !arst_n |->
    !supply_on && div_ratio == DIV_RATIO_ONE && atten_half_db == ATT_FULL && chan_select_n == '1)
    else $error("reset state wrong");
endmodule : synth_mux_assertions

bind synth_spi_command_mux synth_mux_assertions #(.UPD_PULSE_CYCLES(UPD_PULSE_CYCLES)) u_chk (
  .clk_sys(clk_sys), .arst_n(arst_n), .host_serial_clock(host_serial_clock), .host_select_n(host_select_n),
  .host_serial_in(host_serial_in), .host_serial_out(host_serial_out), .supply_on(supply_on),
  .div_factor_bit2(div_factor_bit2), .div_factor_bit1(div_factor_bit1), .div_factor_bit0(div_factor_bit0),
  .div_ratio(div_ratio), .atten_code(atten_code), .atten_half_db(atten_half_db),
  .synth_core_update(synth_core_update), .update_marker(update_marker), .chan_select_n(chan_select_n),
  .chan_sclk(chan_sclk), .chan_mosi(chan_mosi)
);
`default_nettype wire

// *** dv/host_spi_model.sv ***
// Behavioural serial master driving the command multiplexer
`timescale 1ns/100ps
`default_nettype none
module host_spi_model (
  output logic      host_serial_clock,
  output logic      host_select_n,
  output logic      host_serial_in,
  input  wire logic host_serial_out
);
  initial
  begin
    host_serial_clock = 1'b0;
    host_select_n     = 1'b0;
    host_serial_in    = 1'b1;
    // Select rises only once reset has cleared the frame logic
    #2 host_select_n  = 1'b1;
  end
  task automatic open_frame();
    host_select_n = 1'b0;
    #24;
  endtask : open_frame
  // Clock only runs inside frames, 48 ns period
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      host_serial_in = tx[i];
      #24 host_serial_clock = 1'b1;
      rx[i] = host_serial_out;
      #24 host_serial_clock = 1'b0;
    end
  endtask : xbyte
  // Released data line flips so a stale bit is never mistaken for data
  task automatic close_frame();
    #24 host_select_n = 1'b1;
    host_serial_in = ~host_serial_in;
    #48;
  endtask : close_frame
endmodule : host_spi_model
`default_nettype wire

// *** dv/test_synth_spi_command_mux.sv ***
// Self-checking bench for the serial command multiplexer
`timescale 1ns/100ps
`default_nettype none
module test_synth_spi_command_mux;
  import synth_mux_pkg::*;
  localparam logic [7:0] RD_CMDS [5] = '{CMD_FUNC_RD, CMD_DIV_RD, CMD_ATT_RD, CMD_WP_RD, CMD_AUX_RD};
  localparam logic [7:0] CH_CMDS [5] = '{CMD_CORE_CH, CMD_TEMP_CH, CMD_ADC_CH, CMD_POT_CH, CMD_MEM_CH};
  logic             clk_sys = 1'b0;
  logic             arst_n = 1'b1;
  logic             host_serial_clock, host_select_n, host_serial_in, host_serial_out, pll_lock;
  logic             supply_on, rf_out_en, synth_core_power, pot_write_enable, aux_output_pin;
  logic             div_factor_bit2, div_factor_bit1, div_factor_bit0, synth_core_update, update_marker, upd_q;
  logic [6:0]       div_ratio;
  logic [ATT_W-1:0] atten_code, atten_half_db;
  logic [4:0]       chan_select_n, chan_sclk, chan_mosi, chan_miso;
  logic [7:0]       r;
  int               n_mismatch = 0, compares = 0, n_upd = 0, n0;
  always #10 clk_sys = ~clk_sys;
  host_spi_model m (.host_serial_clock(host_serial_clock), .host_select_n(host_select_n),
    .host_serial_in(host_serial_in), .host_serial_out(host_serial_out));
  synth_spi_command_mux #(.UPD_PULSE_CYCLES(2)) dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .host_serial_clock(host_serial_clock), .host_select_n(host_select_n),
    .host_serial_in(host_serial_in), .host_serial_out(host_serial_out), .pll_lock(pll_lock),
    .supply_on(supply_on), .rf_out_en(rf_out_en), .synth_core_power(synth_core_power),
    .div_factor_bit2(div_factor_bit2), .div_factor_bit1(div_factor_bit1), .div_factor_bit0(div_factor_bit0),
    .div_ratio(div_ratio), .atten_code(atten_code), .atten_half_db(atten_half_db),
    .pot_write_enable(pot_write_enable), .synth_core_update(synth_core_update), .update_marker(update_marker),
    .aux_output_pin(aux_output_pin), .chan_select_n(chan_select_n), .chan_sclk(chan_sclk),
    .chan_mosi(chan_mosi), .chan_miso(chan_miso));
  always @(posedge clk_sys)
  begin
    upd_q <= synth_core_update;
    if (synth_core_update === 1'b1 && upd_q === 1'b0)
      n_upd++;
  end
  task automatic close_out();
    $display("Counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Lines move a few system cycles after the frame, so wait past that
  task automatic settle();
    repeat (5) @(posedge clk_sys);
    #1;
  endtask : settle
  task automatic cmd(input logic [7:0] c);
    m.open_frame();
    m.xbyte(c, r);
    m.close_frame();
    settle();
  endtask : cmd
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    m.open_frame();
    m.xbyte(c, r);
    m.xbyte(d, r);
    m.close_frame();
    settle();
  endtask : wr
  task automatic rd(input logic [7:0] c, input logic [7:0] exp);
    m.open_frame();
    m.xbyte(c, r);
    m.xbyte(8'h00, r);
    m.close_frame();
    chk($sformatf("read %h", c), exp, r);
  endtask : rd
  task automatic aux_case(input logic [7:0] d, input logic l, input logic e);
    @(posedge clk_sys) pll_lock <= l;
    wr(CMD_AUX_WR, d);
    chk("aux pin", {7'h00, e}, {7'h00, aux_output_pin});
  endtask : aux_case
  initial
  begin
    #300000;
    n_mismatch++;
    close_out();
  end
  initial
  begin
    pll_lock = 1'b0;
    chan_miso = 5'h00;
    // A real falling edge, so every reset branch runs before the first clock
    #1 arst_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    settle();
    chk("ratio", 8'h01, {1'b0, div_ratio});
    chk("half db", 8'h3f, {2'h0, atten_half_db});
    foreach (RD_CMDS[k]) rd(RD_CMDS[k], 8'h00);
    $display("Test reset finished");
    wr(CMD_FUNC_WR, 8'h99);
    chk("func lines", 8'h07, {5'h00, synth_core_power, rf_out_en, supply_on});
    @(posedge clk_sys) pll_lock <= 1'b1;
    rd(CMD_FUNC_RD, 8'h99);
    @(posedge clk_sys) pll_lock <= 1'b0;
    rd(CMD_FUNC_RD, 8'h19);
    wr(CMD_FUNC_WR, 8'h08);
    chk("func lines", 8'h02, {5'h00, synth_core_power, rf_out_en, supply_on});
    $display("Test func finished");
    wr(CMD_DIV_WR, 8'h05);
    chk("div held", 8'h00, {5'h00, div_factor_bit2, div_factor_bit1, div_factor_bit0});
    rd(CMD_DIV_RD, 8'h05);
    for (int k = 0; k < 8; k++)
    begin
      wr(CMD_DIV_WR, 8'hf8 | k[7:0]);
      cmd(CMD_DIV_APPLY);
      chk("div bits", k[7:0], {5'h00, div_factor_bit2, div_factor_bit1, div_factor_bit0});
      chk("ratio", (k > 5) ? 8'h40 : (8'h01 << k), {1'b0, div_ratio});
    end
    wr(CMD_ATT_WR, 8'hfe);
    chk("att held", 8'h00, {2'h0, atten_code});
    rd(CMD_ATT_RD, 8'hfe);
    cmd(CMD_ATT_APPLY);
    chk("half db", 8'h01, {2'h0, atten_half_db});
    $display("Test buffers finished");
    wr(CMD_DIV_WR, 8'h02);
    wr(CMD_ATT_WR, 8'h00);
    n0 = n_upd;
    cmd(CMD_ALL_APPLY);
    chk("ratio", 8'h04, {1'b0, div_ratio});
    chk("half db", 8'h3f, {2'h0, atten_half_db});
    chk("pulses", 8'h01, 8'(n_upd - n0));
    wr(CMD_DIV_WR, 8'h01);
    cmd(CMD_CORE_UPD);
    chk("ratio", 8'h04, {1'b0, div_ratio});
    chk("pulses", 8'h02, 8'(n_upd - n0));
    $display("Test update finished");
    wr(CMD_WP_WR, 8'h01);
    chk("pot enable", 8'h01, {7'h00, pot_write_enable});
    rd(CMD_WP_RD, 8'h01);
    wr(CMD_WP_WR, 8'h00);
    chk("pot enable", 8'h00, {7'h00, pot_write_enable});
    aux_case(8'h00, 1'b1, 1'b0);
    aux_case(8'h03, 1'b0, 1'b1);
    aux_case(8'h01, 1'b1, 1'b1);
    aux_case(8'h01, 1'b0, 1'b0);
    wr(CMD_AUX_WR, 8'h42);
    rd(CMD_AUX_RD, 8'h42);
    m.open_frame();
    m.xbyte(CMD_DIV_APPLY, r);
    settle();
    chk("marker", 8'h01, {7'h00, update_marker});
    chk("aux pin", 8'h01, {7'h00, aux_output_pin});
    m.close_frame();
    settle();
    chk("marker", 8'h00, {7'h00, update_marker});
    $display("Test aux finished");
    foreach (CH_CMDS[k])
    begin
      @(posedge clk_sys) chan_miso <= 5'h01 << k;
      m.open_frame();
      m.xbyte(CH_CMDS[k], r);
      chk("select", {3'h0, 5'h1f ^ (5'h01 << k)}, {3'h0, chan_select_n});
      m.xbyte(8'ha5, r);
      chk("channel data", 8'hff, r);
      m.close_frame();
      chk("select", 8'h1f, {3'h0, chan_select_n});
    end
    m.open_frame();
    m.xbyte(8'h20, r);
    chk("select", 8'h1f, {3'h0, chan_select_n});
    m.xbyte(8'h07, r);
    m.close_frame();
    rd(CMD_DIV_RD, 8'h01);
    $display("Test channels finished");
    close_out();
  end
endmodule : test_synth_spi_command_mux
`default_nettype wire
